/* File: dv/deuc_coupler_model.sv */
/* Coupler model driving the control byte. Assumes the bench posts requests on falling edges. */
`timescale 1ns/1ps
`default_nettype none
module deuc_coupler_model import deuc_pkg::*; (input wire logic clk,
  input wire deuc_byte_type reqCtrl, output deuc_byte_type controlByte = 8'h00);
  always @(negedge clk) controlByte <= reqCtrl & 8'h7f;
endmodule
`default_nettype wire

/* File: dv/deuc_dual_up_counter_bench.sv */
/* Bench of the dual up counter. Assumes the coupler model and the checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module deuc_dual_up_counter_bench import deuc_pkg::*;;
  logic clk = 0, reset_n = 0, firstSwitchOutput, secondSwitchOutput;
  logic countInputOne = 0, countInputTwo = 0;
  logic [3:0] channelLeds;
  deuc_byte_type reqCtrl = 8'h00, controlByte, statusByte;
  deuc_count_type presetWordOne = 16'hfffe, presetWordTwo = 16'h1234, countWordOne, countWordTwo;
  int n_mismatch = 0, compares = 0, cyc = 0;
  always #12.5 clk = ~clk;
  deuc_coupler_model u_host(.*);
  deuc_dual_up_counter u_dut(.*);
  task automatic chk(input string what, input deuc_count_type exp, got);
    compares++;
    if (got !== exp) $display("FAIL %s expected %h seen %h", what, exp, got);
    n_mismatch += int'(got !== exp);
  endtask
  task automatic chkByte(input string what, input deuc_byte_type exp, got);
    compares++;
    if (got !== exp) $display("FAIL %s expected %h seen %h", what, exp, got);
    n_mismatch += int'(got !== exp);
  endtask
  // Inputs toggle one clock each way, so every pulse on a channel whose set bit is low is one counted edge.
  task automatic pulse(input deuc_byte_type c, input logic [1:0] m, input int n);
    reqCtrl <= c;
    repeat (2 * n) @(negedge clk) {countInputTwo, countInputOne} <= {countInputTwo, countInputOne} ^ m;
  endtask
  task automatic results;
    n_mismatch += int'(cyc >= 500);
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk) if (++cyc == 500) results();
  initial begin
    repeat (4) @(negedge clk);
    reset_n <= 1'b1;
    chk("resetOne", 16'h0000, countWordOne);
    pulse(8'h00, 2'b01, 3);
    pulse(8'h00, 2'b11, 2);
    chk("countOne", 16'h0005, countWordOne);
    pulse(8'h30, 2'b11, 2);
    chkByte("ack", 8'h33, statusByte);
    chk("heldOne", 16'hfffe, countWordOne);
    pulse(8'hcf, 2'b01, 2);
    chk("wrap", 16'h0000, countWordOne);
    chk("countTwo", 16'h1234, countWordTwo);
    chkByte("status", 8'h0d, statusByte);
    reset_n <= 1'b0;
    @(negedge clk);
    chk("resetTwo", 16'h0000, countWordTwo);
    chkByte("resetStatus", 8'h00, statusByte);
    reset_n <= 1'b1;
    @(negedge clk);
    chkByte("pins", 8'h3c, {2'b00, secondSwitchOutput, firstSwitchOutput, channelLeds});
    results();
  end
endmodule
bind deuc_dual_up_counter deuc_props u_props(.*);
`default_nettype wire

/* File: dv/deuc_props.sv */
/* Port checker of the dual up counter. Assumes it is bound onto the counter module. */
`timescale 1ns/1ps
`default_nettype none
module deuc_props import deuc_pkg::*; (
  input wire logic clk, reset_n, countInputOne, countInputTwo, firstSwitchOutput,
  input wire logic secondSwitchOutput, input wire logic [3:0] channelLeds,
  input wire deuc_byte_type controlByte, statusByte,
  input wire deuc_count_type presetWordOne, presetWordTwo, countWordOne, countWordTwo);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_up(pin, hold); !pin ##1 (pin && !hold); endsequence
  property p_upOne; s_up(countInputOne, controlByte[5]) |=>
    countWordOne == $past(countWordOne) + 16'h0001; endproperty
  a_upOne: assert property (p_upOne) else $error("count one missed an edge");
  property p_upTwo; s_up(countInputTwo, controlByte[4]) |=>
    countWordTwo == $past(countWordTwo) + 16'h0001; endproperty
  a_upTwo: assert property (p_upTwo) else $error("count two missed an edge");
  property p_setOne; controlByte[5] |=>
    statusByte[5] && countWordOne == $past(presetWordOne); endproperty
  a_setOne: assert property (p_setOne) else $error("preset one not held");
  property p_setTwo; controlByte[4] |=>
    statusByte[4] && countWordTwo == $past(presetWordTwo); endproperty
  a_setTwo: assert property (p_setTwo) else $error("preset two not held");
  property p_out; 1'b1 |=>
    {secondSwitchOutput, firstSwitchOutput} == $past(controlByte[3:2]); endproperty
  a_out: assert property (p_out) else $error("outputs do not follow control");
  property p_in; 1'b1 |=> statusByte[1:0] == $past({countInputTwo, countInputOne}); endproperty
  a_in: assert property (p_in) else $error("input levels misreported");
  property p_stat; statusByte[3:2] == {secondSwitchOutput, firstSwitchOutput}; endproperty
  a_stat: assert property (p_stat) else $error("output levels misreported");
  property p_led; channelLeds == statusByte[3:0]; endproperty
  a_led: assert property (p_led) else $error("indicator mismatch");
endmodule
`default_nettype wire

/* File: hw/deuc_defines.svh */
/*
  Constants of the dual 16-bit up counter: process image bit positions,
  widths, reset values and the pulse-rate limits.
  Assumes the includer uses the macros by name and includes this file once.
*/
`ifndef DEUC_DEFINES_SVH
`define DEUC_DEFINES_SVH
`define DEUC_COUNT_WIDTH 16
`define DEUC_BYTE_WIDTH 8
`define DEUC_BIT_SET_ONE 5
`define DEUC_BIT_SET_TWO 4
`define DEUC_BIT_OUT_TWO 3
`define DEUC_BIT_OUT_ONE 2
`define DEUC_BIT_IN_TWO 1
`define DEUC_BIT_IN_ONE 0
`define DEUC_COUNT_RESET 16'h0000
`define DEUC_STATUS_RESET 8'h00
`define DEUC_MAX_RATE_HZ 5000
`define DEUC_MAX_RATE_DYN_HZ 2000
`define DEUC_CLK_HZ 40000000
`define DEUC_MIN_PERIOD_CYCLES (`DEUC_CLK_HZ / `DEUC_MAX_RATE_HZ)
`endif

/* File: hw/deuc_dual_up_counter.sv */
/*
  Two independent 16-bit rising-edge up counters with preset and hold,
  two directly driven binary outputs and channel indicators.
  Assumes the process image ports and field inputs are synchronous to clk
  and that the coupler refreshes the control byte and preset words as levels.
*/
`timescale 1ns/1ps
`default_nettype none
`include "deuc_defines.svh"
module deuc_dual_up_counter
  import deuc_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Process image from the coupler.
  input wire deuc_byte_type controlByte,
  input wire deuc_count_type presetWordOne,
  input wire deuc_count_type presetWordTwo,
  // Process image to the coupler.
  output deuc_byte_type statusByte,
  output deuc_count_type countWordOne,
  output deuc_count_type countWordTwo,
  // Field inputs; count_input_two sits on the former direction pin.
  input wire logic countInputOne,
  input wire logic countInputTwo,
  // Field outputs.
  output logic firstSwitchOutput,
  output logic secondSwitchOutput,
  // Indicators, bit 0 input one, 1 input two, 2 output one, 3 output two.
  output logic [3:0] channelLeds
);

  deuc_count_type countOne_reg;
  deuc_count_type countOne_next;
  deuc_count_type countTwo_reg;
  deuc_count_type countTwo_next;
  logic inOnePrev_reg;
  logic inOnePrev_next;
  logic inTwoPrev_reg;
  logic inTwoPrev_next;
  logic outOne_reg;
  logic outOne_next;
  logic outTwo_reg;
  logic outTwo_next;
  deuc_byte_type status_reg;
  deuc_byte_type status_next;
  logic [3:0] leds_reg;
  logic [3:0] leds_next;
  logic setOne;
  logic setTwo;

  // Inputs are far slower than clk, so one sample per edge is ample margin.
  function automatic logic risingEdge(input logic prev, input logic now);
    risingEdge = now && !prev;
  endfunction

  // Status and indicators show the same four levels, so both pack them here.
  function automatic logic [3:0] channelLevels(input logic outTwo, input logic outOne,
                                               input logic inTwo, input logic inOne);
    channelLevels = {outTwo, outOne, inTwo, inOne};
  endfunction

  // A set request wins over a coincident edge, so a held counter never drifts.
  function automatic deuc_count_type advance(input deuc_count_type value,
                                             input logic prev, input logic now,
                                             input logic setReq,
                                             input deuc_count_type preset);
    if (setReq) begin
      advance = preset;
    end else if (risingEdge(prev, now)) begin
      advance = value + 16'h0001;
    end else begin
      advance = value;
    end
  endfunction

  // The set bits are levels; a counter follows its preset word while one is high.
  always_comb begin
    setOne = controlByte[`DEUC_BIT_SET_ONE];
    setTwo = controlByte[`DEUC_BIT_SET_TWO];
  end

  always_comb begin
    inOnePrev_next = countInputOne;
  end

  // Cleared to the idle low level, so an input already high when reset is released counts as one edge.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      inOnePrev_reg <= 1'b0;
    end else begin
      inOnePrev_reg <= inOnePrev_next;
    end
  end

  always_comb begin
    inTwoPrev_next = countInputTwo;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      inTwoPrev_reg <= 1'b0;
    end else begin
      inTwoPrev_reg <= inTwoPrev_next;
    end
  end

  always_comb begin
    countOne_next = advance(countOne_reg, inOnePrev_reg, countInputOne,
                            setOne, presetWordOne);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      countOne_reg <= `DEUC_COUNT_RESET;
    end else begin
      countOne_reg <= countOne_next;
    end
  end

  always_comb begin
    countTwo_next = advance(countTwo_reg, inTwoPrev_reg, countInputTwo,
                            setTwo, presetWordTwo);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      countTwo_reg <= `DEUC_COUNT_RESET;
    end else begin
      countTwo_reg <= countTwo_next;
    end
  end

  always_comb begin
    outOne_next = controlByte[`DEUC_BIT_OUT_ONE];
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      outOne_reg <= 1'b0;
    end else begin
      outOne_reg <= outOne_next;
    end
  end

  always_comb begin
    outTwo_next = controlByte[`DEUC_BIT_OUT_TWO];
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      outTwo_reg <= 1'b0;
    end else begin
      outTwo_reg <= outTwo_next;
    end
  end

  // Bits 7 and 6 stay at zero, since the control byte leaves them unused.
  always_comb begin
    status_next = `DEUC_STATUS_RESET;
    status_next[`DEUC_BIT_SET_ONE] = setOne;
    status_next[`DEUC_BIT_SET_TWO] = setTwo;
    status_next[`DEUC_BIT_OUT_TWO:`DEUC_BIT_IN_ONE] =
        channelLevels(outTwo_next, outOne_next, countInputTwo, countInputOne);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_reg <= `DEUC_STATUS_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  always_comb begin
    leds_next = channelLevels(outTwo_next, outOne_next, countInputTwo, countInputOne);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      leds_reg <= 4'h0;
    end else begin
      leds_reg <= leds_next;
    end
  end

  assign countWordOne = countOne_reg;
  assign countWordTwo = countTwo_reg;
  assign statusByte = status_reg;
  assign firstSwitchOutput = outOne_reg;
  assign secondSwitchOutput = outTwo_reg;
  assign channelLeds = leds_reg;

endmodule
`default_nettype wire

/* File: hw/deuc_pkg.sv */
/*
  Types of the dual 16-bit up counter.
  Assumes the defines header is compiled alongside.
*/
`include "deuc_defines.svh"
package deuc_pkg;
  typedef logic [`DEUC_COUNT_WIDTH-1:0] deuc_count_type;
  typedef logic [`DEUC_BYTE_WIDTH-1:0] deuc_byte_type;
endpackage
